// ===== qdc_consts.svh
// Register offsets, field positions, reset values and timing figures of the decoder.
`ifndef QDC_CONSTS_SVH
`define QDC_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define QDC_OFS_TASK      12'h000
`define QDC_OFS_IEN_SET   12'h304
`define QDC_OFS_IEN_CLR   12'h308
`define QDC_OFS_STATUS    12'h600
`define QDC_OFS_ENABLE    12'h500
`define QDC_OFS_POL       12'h504
`define QDC_OFS_PER       12'h508
`define QDC_OFS_SAMPLE    12'h50c
`define QDC_OFS_REPPER    12'h510
`define QDC_OFS_ACC       12'h514
`define QDC_OFS_DBL       12'h544
// ==========================================================
// Event bit positions, shared by status and enable registers
`define QDC_EV_SAMPLE     0
`define QDC_EV_REPORT     1
`define QDC_EV_ACCUMULATOR_OVERFLOW_EVENT      2
`define QDC_EV_DBL        3
`define QDC_EV_STOPPED    4
`define QDC_EV_N          5
// ==========================================================
// Task register bits
`define QDC_TASK_START    0
`define QDC_TASK_STOP     1
`define QDC_TASK_CLR      2
// ==========================================================
// Reset values and field limits
`define QDC_RST_REPPER    8'h0a
`define QDC_PER_MAX       4'ha
`define QDC_DBL_CODE      3'sh2
// ==========================================================
// Timing: base sample interval and clock rate
`define QDC_BASE_US       128
`define QDC_CLK_MHZ       200
`define QDC_BASE_CYC      (`QDC_BASE_US * `QDC_CLK_MHZ)
// ==========================================================
// Bus responses
`define QDC_RESP_OKAY     2'h0
`define QDC_RESP_SLVERR   2'h2
`endif

// ===== qdc_ctrl.sv
// Quadrature decoder with its control registers behind an AXI4-Lite slave.
//
// Operation
// - Writing one to an enable-clear bit disables that event; reads show enables.
// - Report event fires after report period samples only when motion accumulator nonzero.
// - Double event fires after report period samples only when double accumulator nonzero.
// - Enable one claims input and indicator pins; zero leaves them inactive.
// - Indicator lights low when polarity is zero, high when polarity is one.
// - Interval codes 0 to 10 give 128 us doubling; sample refreshed each sample.
// - Samples are signed two's complement; value 2 marks a double transition.
`timescale 1ns/10ps
`default_nettype none
`include "qdc_consts.svh"

module qdc_ctrl #(
    parameter int BASE_CYC = `QDC_BASE_CYC,
    parameter int ACC_W    = 16,
    parameter int DBL_W    = 4
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output var  logic [1:0]  s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    // Encoder phases and indicator pin
    input  wire logic        phase_a,
    input  wire logic        phase_b,
    output var  logic        led_out,
    output var  logic        led_oe,
    // Interrupt
    output var  logic        irq
);
    import qdc_pkg::*;

    // Refuses parameter values that the counters and read-back paths cannot hold.
    if (BASE_CYC < 1 || ACC_W < 4 || ACC_W > 32 || DBL_W < 1 || DBL_W > 32) begin
        $error("qdc_ctrl: unsupported parameter values");
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Decoding and transition functions
    function automatic qdc_reg_t reg_sel(input logic [11:0] a);
        case (a)
            `QDC_OFS_TASK:    reg_sel = QDC_R_TASK;
            `QDC_OFS_IEN_SET: reg_sel = QDC_R_IEN_SET;
            `QDC_OFS_IEN_CLR: reg_sel = QDC_R_IEN_CLR;
            `QDC_OFS_STATUS:  reg_sel = QDC_R_STATUS;
            `QDC_OFS_ENABLE:  reg_sel = QDC_R_ENABLE;
            `QDC_OFS_POL:     reg_sel = QDC_R_POL;
            `QDC_OFS_PER:     reg_sel = QDC_R_PER;
            `QDC_OFS_SAMPLE:  reg_sel = QDC_R_SAMPLE;
            `QDC_OFS_REPPER:  reg_sel = QDC_R_REPPER;
            `QDC_OFS_ACC:     reg_sel = QDC_R_ACC;
            `QDC_OFS_DBL:     reg_sel = QDC_R_DBL;
            default:          reg_sel = QDC_R_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [1:0] gray_pos(input logic [1:0] ab);
        gray_pos = {ab[1], ab[1] ^ ab[0]};
    endfunction : gray_pos

    // Step along the gray cycle: +1, -1, 0 or the double marker.
    function automatic logic signed [2:0] step(input logic [1:0] p, input logic [1:0] n);
        logic [1:0] d;
        d = gray_pos(n) - gray_pos(p);
        case (d)
            2'h0:    step = 3'sh0;
            2'h1:    step = 3'sh1;
            2'h2:    step = `QDC_DBL_CODE;
            default: step = -3'sh1;
        endcase
    endfunction : step

    // ==========================================================
    // Registers and state
    logic [`QDC_EV_N-1:0] irq_en;
    logic [`QDC_EV_N-1:0] status;
    logic                 dec_en;
    logic                 pol;
    logic [3:0]           per_code;
    logic [7:0]           rep_per;
    logic signed [2:0]    sample_val;
    logic signed [ACC_W-1:0] acc;
    logic [DBL_W-1:0]     dbl_acc;
    qdc_state_t           state;
    logic                 aw_got;
    logic                 w_got;
    logic [11:0]          aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 wr_do;
    logic                 rd_do;
    qdc_reg_t             wr_sel;
    qdc_reg_t             rd_sel;
    logic                 task_start;
    logic                 task_stop;
    logic                 task_clr;

    assign wr_do      = aw_got && w_got && !s_axi_bvalid;
    assign rd_do      = s_axi_arvalid && s_axi_arready;
    assign wr_sel     = reg_sel(aw_addr);
    assign rd_sel     = reg_sel(s_axi_araddr);
    assign task_start = wr_do && wr_sel == QDC_R_TASK && w_strb[0] && w_data[`QDC_TASK_START];
    assign task_stop  = wr_do && wr_sel == QDC_R_TASK && w_strb[0] && w_data[`QDC_TASK_STOP];
    assign task_clr   = wr_do && wr_sel == QDC_R_TASK && w_strb[0] && w_data[`QDC_TASK_CLR];

    // ==========================================================
    // Write channel
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `QDC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == QDC_R_NONE) ? `QDC_RESP_SLVERR : `QDC_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got        <= 1'b0;
                w_got         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Software-written configuration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_en   <= '0;
            dec_en   <= 1'b0;
            pol      <= 1'b0;
            per_code <= 4'h0;
            rep_per  <= `QDC_RST_REPPER;
        end else if (wr_do && w_strb[0]) begin
            case (wr_sel)
                QDC_R_IEN_SET: irq_en <= irq_en | w_data[`QDC_EV_N-1:0];
                QDC_R_IEN_CLR: irq_en <= irq_en & ~w_data[`QDC_EV_N-1:0];
                QDC_R_ENABLE:  dec_en <= w_data[0];
                QDC_R_POL:     pol    <= w_data[0];
                QDC_R_PER: begin
                    // Codes above the last doubling step are ignored.
                    if (w_data[3:0] <= `QDC_PER_MAX && w_data[7:4] == 4'h0) begin
                        per_code <= w_data[3:0];
                    end
                end
                QDC_R_REPPER:  rep_per <= w_data[7:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Pin synchronisers and sample divider
    logic [1:0]  ab_meta;
    logic [1:0]  ab_sync;
    logic [1:0]  ab_prev;
    logic [31:0] div_cnt;
    logic [31:0] div_top;
    logic        samp_tick;

    // Interval is the base period doubled once per code step.
    assign div_top   = (32'(BASE_CYC) << per_code) - 32'h1;
    // A shorter interval written mid-run ends the current count instead of wrapping it.
    assign samp_tick = state == QDC_RUN && div_cnt >= div_top;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ab_meta <= 2'h0;
            ab_sync <= 2'h0;
        end else begin
            ab_meta <= {phase_a, phase_b};
            ab_sync <= ab_meta;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= QDC_IDLE;
        end else begin
            case (state)
                QDC_IDLE: if (task_start && dec_en) state <= QDC_RUN;
                QDC_RUN:  if (task_stop || !dec_en) state <= QDC_IDLE;
                default:  state <= QDC_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || state != QDC_RUN || samp_tick) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

    // ==========================================================
    // Sample, accumulators and report counter
    logic signed [2:0]       delta;
    logic signed [ACC_W:0]   acc_sum;
    logic                    acc_ovf;
    logic [DBL_W-1:0]        next_dbl;
    logic signed [ACC_W-1:0] next_acc;
    logic [7:0]              rep_cnt;
    logic                    rep_hit;
    logic                    ev_sample;
    logic                    ev_report;
    logic                    ev_accumulator_overflow_event;
    logic                    ev_dbl;
    logic                    ev_stop;

    assign delta   = step(ab_prev, ab_sync);
    assign acc_sum = {acc[ACC_W-1], acc} + (ACC_W+1)'(delta);
    assign acc_ovf = samp_tick && delta != `QDC_DBL_CODE && acc_sum[ACC_W] != acc_sum[ACC_W-1];
    assign rep_hit = samp_tick && (rep_cnt + 8'h1 >= rep_per);

    always_comb begin
        next_acc = acc;
        next_dbl = dbl_acc;
        if (task_clr) begin
            next_acc = '0;
            next_dbl = '0;
        end else if (samp_tick) begin
            if (delta == `QDC_DBL_CODE) begin
                if (dbl_acc != '1) next_dbl = dbl_acc + 1'b1;
            end else if (!acc_ovf) begin
                next_acc = acc_sum[ACC_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ab_prev    <= 2'h0;
            sample_val <= 3'sh0;
            acc        <= '0;
            dbl_acc    <= '0;
            rep_cnt    <= 8'h0;
        end else begin
            acc     <= next_acc;
            dbl_acc <= next_dbl;
            if (state == QDC_IDLE) begin
                ab_prev <= ab_sync;
                rep_cnt <= 8'h0;
            end else if (samp_tick) begin
                ab_prev    <= ab_sync;
                sample_val <= delta;
                rep_cnt    <= rep_hit ? 8'h0 : rep_cnt + 8'h1;
            end
        end
    end

    // Report and double events look at the values the accumulators take now.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ev_sample <= 1'b0;
            ev_report <= 1'b0;
            ev_accumulator_overflow_event  <= 1'b0;
            ev_dbl    <= 1'b0;
            ev_stop   <= 1'b0;
        end else begin
            ev_sample <= samp_tick;
            ev_report <= rep_hit && next_acc != '0;
            ev_dbl    <= rep_hit && next_dbl != '0;
            ev_accumulator_overflow_event  <= acc_ovf;
            ev_stop   <= state == QDC_RUN && (task_stop || !dec_en);
        end
    end

    // ==========================================================
    // Status, interrupt and pins
    logic [`QDC_EV_N-1:0] ev_vec;

    assign ev_vec = {ev_stop, ev_dbl, ev_accumulator_overflow_event, ev_report, ev_sample};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status <= '0;
        end else if (rd_do && rd_sel == QDC_R_STATUS) begin
            status <= ev_vec;
        end else begin
            status <= status | ev_vec;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq     <= 1'b0;
            led_out <= 1'b0;
            led_oe  <= 1'b0;
        end else begin
            irq     <= |(status & irq_en);
            led_oe  <= dec_en;
            led_out <= dec_en && ((state == QDC_RUN) ? pol : !pol);
        end
    end

    // ==========================================================
    // Read channel
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `QDC_RESP_OKAY;
        end else if (rd_do) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `QDC_RESP_OKAY;
            case (rd_sel)
                QDC_R_IEN_SET, QDC_R_IEN_CLR: s_axi_rdata <= 32'(irq_en);
                QDC_R_STATUS: s_axi_rdata <= 32'(status);
                QDC_R_ENABLE: s_axi_rdata <= {31'h0, dec_en};
                QDC_R_POL:    s_axi_rdata <= {31'h0, pol};
                QDC_R_PER:    s_axi_rdata <= {28'h0, per_code};
                QDC_R_SAMPLE: s_axi_rdata <= 32'(signed'(sample_val));
                QDC_R_REPPER: s_axi_rdata <= {24'h0, rep_per};
                QDC_R_ACC:    s_axi_rdata <= 32'(signed'(acc));
                QDC_R_DBL:    s_axi_rdata <= 32'(dbl_acc);
                QDC_R_TASK:   s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `QDC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    a_en_clear_bits: assert property (
        (wr_do && wr_sel == QDC_R_IEN_CLR && w_strb[0])
        |=> (irq_en & $past(w_data[`QDC_EV_N-1:0])) == '0)
        else $error("enable bit survived a clear write");
    a_report_nonzero: assert property (
        $rose(ev_report) |-> acc != '0 && $past(rep_hit))
        else $error("report event without motion or full period");
    a_double_nonzero: assert property (
        ev_dbl |-> dbl_acc != '0 && $past(rep_hit))
        else $error("double event without double count");
    a_pins_release: assert property (
        !dec_en |=> !led_oe && !led_out)
        else $error("pins driven while decoder disabled");
    a_led_polarity: assert property (
        (dec_en && state == QDC_RUN && !task_stop) |=> led_out == $past(pol))
        else $error("indicator level does not match polarity");
    a_tick_spacing: assert property (
        (samp_tick && !$changed(per_code)) |=> !samp_tick [*1] ##0 div_cnt == 32'h0)
        else $error("sample divider did not restart");
    a_sample_fresh: assert property (
        ev_sample |-> sample_val == $past(delta))
        else $error("sample value not refreshed");
    a_double_mark: assert property (
        (samp_tick && delta == `QDC_DBL_CODE && !task_clr && dbl_acc != '1)
        |=> dbl_acc == $past(dbl_acc) + 1'b1 ##1 status[`QDC_EV_SAMPLE])
        else $error("double transition not counted");
    a_irq_level: assert property (
        (|(status & irq_en)) |=> irq)
        else $error("interrupt low with enabled event pending");

endmodule : qdc_ctrl

`default_nettype wire

// ===== qdc_ctrl_test.sv
// Self-checking testbench of the quadrature decoder control block.
`timescale 1ns/10ps
`default_nettype none
`include "qdc_consts.svh"

module qdc_ctrl_test;
    // ==========================================================
    // Clock, reset and bus signals
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        awv     = 1'b0;
    logic        wv      = 1'b0;
    logic        br      = 1'b0;
    logic        arv     = 1'b0;
    logic        rr      = 1'b0;
    logic [11:0] awa     = 12'h000;
    logic [11:0] ara     = 12'h000;
    logic [31:0] wd      = 32'h0;
    logic        awr, wr_rdy, bv, arr, rv, pa, pb, led_out, led_oe, irq;
    logic [1:0]  bp, rp;
    logic [31:0] rdat;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          steps[$]  = '{0, 1, 0, -1, 2, 0};

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    qdc_ctrl #(.BASE_CYC(8)) uut (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rp),
        .phase_a(pa), .phase_b(pb), .led_out(led_out), .led_oe(led_oe), .irq(irq)
    );

    qdc_encoder_model enc (.ref_clk(ref_clk), .phase_a(pa), .phase_b(pb));

    // ==========================================================
    // Reporting
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic tmo(input string nm);
        err_total++;
        $display("CHECK FAILED %s expected answer seen timeout", nm);
        wrap_up();
    endtask : tmo

    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er = `QDC_RESP_OKAY);
        int n;
        @(posedge ref_clk);
        awv <= 1'b1;
        awa <= a;
        wv  <= 1'b1;
        wd  <= d;
        br  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wr_rdy === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        if (n == 50) tmo("write");
        br <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bp});
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      input logic [1:0] er = `QDC_RESP_OKAY);
        int n;
        @(posedge ref_clk);
        arv <= 1'b1;
        ara <= a;
        rr  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arv && arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        if (n == 50) tmo("read");
        rr <= 1'b0;
        d = rdat;
        chk("rresp", {30'h0, er}, {30'h0, rp});
    endtask : rd

    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] ex,
                      input logic [1:0] er = `QDC_RESP_OKAY);
        logic [31:0] v;
        rd(a, v, er);
        chk(nm, ex, v);
    endtask : rc

    task automatic wait_irq(output int t);
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge ref_clk);
            if (irq === 1'b1) break;
        end
        if (n == 20000) tmo("irq");
        t = cyc;
    endtask : wait_irq

    // ==========================================================
    // Main sequence
    initial begin
        int          t1, t2, m, acc, dbl;
        logic [31:0] v;
        void'($urandom(27));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rc("polarity", `QDC_OFS_POL, 0);
        rc("interval", `QDC_OFS_PER, 0);
        rc("enables", `QDC_OFS_IEN_CLR, 0);
        rc("unmapped", 12'h0f0, 0, `QDC_RESP_SLVERR);
        wr(12'h0f0, $urandom, `QDC_RESP_SLVERR);
        chk("pin drive off", 0, {31'h0, led_oe});
        // Each disable bit alone, then random masks.
        for (int i = 0; i < 8; i++) begin
            m = (i < 5) ? (1 << i) : ($urandom & 32'h1f);
            wr(`QDC_OFS_IEN_SET, 32'h1f);
            wr(`QDC_OFS_IEN_CLR, m);
            rc("enables", `QDC_OFS_IEN_CLR, 32'h1f & ~m);
            rc("enables set view", `QDC_OFS_IEN_SET, 32'h1f & ~m);
        end
        wr(`QDC_OFS_IEN_CLR, 32'h1f);
        wr(`QDC_OFS_IEN_SET, 32'h1);
        wr(`QDC_OFS_ENABLE, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk("pin drive on", 1, {31'h0, led_oe});
        chk("light idle low pol", 1, {31'h0, led_out});
        wr(`QDC_OFS_POL, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk("light idle high pol", 0, {31'h0, led_out});
        wr(`QDC_OFS_REPPER, 32'h1);
        wr(`QDC_OFS_PER, 32'h2);
        wr(`QDC_OFS_TASK, 32'h5);
        repeat (3) @(posedge ref_clk);
        chk("light lit high pol", 1, {31'h0, led_out});
        wr(`QDC_OFS_POL, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("light lit low pol", 0, {31'h0, led_out});
        acc = 0;
        dbl = 0;
        foreach (steps[i]) begin
            wait_irq(t1);
            rd(`QDC_OFS_STATUS, v);
            enc.move(steps[i]);
            if (steps[i] == 2) dbl++;
            else acc += steps[i];
            wait_irq(t2);
            rc("status", `QDC_OFS_STATUS, 1 | (32'(acc != 0) << 1) | (32'(dbl != 0) << 3));
            rc("sample", `QDC_OFS_SAMPLE, steps[i]);
            repeat (2) @(posedge ref_clk);
            chk("irq after clear", 0, {31'h0, irq});
        end
        for (int c = 0; c <= 10; c++) begin
            wr(`QDC_OFS_PER, c);
            wait_irq(t1);
            rd(`QDC_OFS_STATUS, v);
            wait_irq(t1);
            rd(`QDC_OFS_STATUS, v);
            wait_irq(t2);
            chk("interval cycles", 8 << c, t2 - t1);
        end
        wr(`QDC_OFS_PER, 32'hb);
        rc("interval kept", `QDC_OFS_PER, 10);
        wr(`QDC_OFS_PER, 32'h0);
        wr(`QDC_OFS_IEN_CLR, 32'h1);
        repeat (40) @(posedge ref_clk);
        chk("irq masked", 0, {31'h0, irq});
        rc("status masked", `QDC_OFS_STATUS, 32'h9);
        wr(`QDC_OFS_IEN_SET, 32'h10);
        wr(`QDC_OFS_TASK, 32'h2);
        repeat (3) @(posedge ref_clk);
        chk("irq stopped", 1, {31'h0, irq});
        chk("light idle", 1, {31'h0, led_out});
        rd(`QDC_OFS_STATUS, v);
        chk("stopped event", 1, {31'h0, v[`QDC_EV_STOPPED]});
        wr(`QDC_OFS_ENABLE, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("pin drive released", 0, {31'h0, led_oe});
        chk("light released", 0, {31'h0, led_out});
        wrap_up();
    end
endmodule : qdc_ctrl_test
`default_nettype wire

// ===== qdc_encoder_model.sv
// Quadrature encoder model that steps its two phases on request.
`timescale 1ns/10ps
`default_nettype none

module qdc_encoder_model (
    // Clock
    input  wire logic ref_clk,
    // Encoder phases
    output var  logic phase_a,
    output var  logic phase_b
);
    int pos = 0;

    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end

    // Moves one step forward, one back, or two positions at once for a double transition.
    task automatic move(input int s);
        pos = (pos + s + 4) % 4;
        @(posedge ref_clk);
        phase_a <= (pos == 2) || (pos == 3);
        phase_b <= (pos == 1) || (pos == 2);
    endtask : move
endmodule : qdc_encoder_model
`default_nettype wire

// ===== qdc_pkg.sv
// Types shared by the quadrature decoder control logic.
package qdc_pkg;
    // ==========================================================
    // Register selector and run state
    typedef enum {
        QDC_R_NONE, QDC_R_TASK, QDC_R_IEN_SET, QDC_R_IEN_CLR, QDC_R_STATUS,
        QDC_R_ENABLE, QDC_R_POL, QDC_R_PER, QDC_R_SAMPLE, QDC_R_REPPER,
        QDC_R_ACC, QDC_R_DBL
    } qdc_reg_t;
    typedef enum {QDC_IDLE, QDC_RUN} qdc_state_t;
endpackage : qdc_pkg
